// >>> rar_cfg.svh
// Widths and reset values for the return and rotate executor.
// Included by the package and the executor; holds definitions only.
`ifndef RAR_CFG_SVH
`define RAR_CFG_SVH

`define RAR_DATA_W    8
`define RAR_FILE_W    7
`define RAR_PC_W      9
`define RAR_RST_DATA  8'h00
`define RAR_RST_FILE  7'h00
`define RAR_RST_PC    9'h000

`endif

// >>> rar_pkg.sv
// Types shared by the return and rotate executor.
// Assumes rar_cfg.svh is on the include path.
`include "rar_cfg.svh"

package rar_pkg;

	typedef logic [`RAR_DATA_W-1:0] rar_data_t;
	typedef logic [`RAR_FILE_W-1:0] rar_fidx_t;
	typedef logic [`RAR_PC_W-1:0]   rar_pc_t;

	// Code 2'h3 is not an instruction of this block
	typedef enum logic [1:0] {
		RAR_OP_RETURN_WITH_LITERAL = 2'h0,
		RAR_OP_RETURN              = 2'h1,
		RAR_OP_ROTATE_LEFT_VIA_CARRY = 2'h2
	} rar_op_e;

	// Gray coded, one step per extra cycle
	typedef enum logic [0:0] {
		RAR_ST_IDLE  = 1'h0,
		RAR_ST_FLUSH = 1'h1
	} rar_state_e;

endpackage : rar_pkg

// >>> rar_exec.sv
// Executor for the literal return, plain return and rotate-left-through-carry instructions.
// Assumes the core presents one decoded instruction with its operands and the
// addressed file register value, all synchronous to clk_sys, and applies the
// one-cycle write, load and pop pulses that this block drives.
`timescale 1ns/100ps
`default_nettype none
`include "rar_cfg.svh"

module rar_exec (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// Instruction in
	input  wire logic                  instr_valid,
	input  wire logic [1:0]            instr_op,
	input  wire logic [`RAR_DATA_W-1:0] instr_literal,
	input  wire logic [`RAR_FILE_W-1:0] instr_file_idx,
	input  wire logic                  instr_dest,
	output logic                       instr_ready,
	output logic                       retire,
	// Operand sources
	input  wire logic [`RAR_DATA_W-1:0] file_rdata,
	input  wire logic                  carry_in,
	input  wire logic [`RAR_PC_W-1:0]   stack_top_entry,
	// Accumulator write
	output logic                       w_we,
	output logic [`RAR_DATA_W-1:0]      w_wdata,
	// File register write
	output logic                       file_we,
	output logic [`RAR_FILE_W-1:0]      file_waddr,
	output logic [`RAR_DATA_W-1:0]      file_wdata,
	// Carry write
	output logic                       carry_we,
	output logic                       carry_wdata,
	// Program counter and stack
	output logic                       pc_load,
	output logic [`RAR_PC_W-1:0]        pc_value,
	output logic                       stack_pop
);

	// Nine-bit rotation: {new carry, result}
	function automatic logic [`RAR_DATA_W:0] rot_left(input logic [`RAR_DATA_W-1:0] v, input logic c);
		rot_left = {v, c};
	endfunction : rot_left

	rar_pkg::rar_state_e state_q;
	rar_pkg::rar_op_e    op;
	logic                take;
	logic [`RAR_DATA_W:0] rot;

	assign op   = rar_pkg::rar_op_e'(instr_op);
	assign take = instr_valid && instr_ready;
	assign rot  = rot_left(file_rdata, carry_in);

	// Sequencing; a return holds ready low for its second cycle
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q     <= rar_pkg::RAR_ST_IDLE;
			instr_ready <= 1'b0;
			retire      <= 1'b0;
		end else begin
			retire      <= 1'b0;
			instr_ready <= 1'b1;
			unique case (state_q)
				rar_pkg::RAR_ST_IDLE: begin
					if (take) begin
						unique case (op)
							rar_pkg::RAR_OP_RETURN_WITH_LITERAL,
							rar_pkg::RAR_OP_RETURN: begin
								state_q     <= rar_pkg::RAR_ST_FLUSH;
								instr_ready <= 1'b0;
							end
							rar_pkg::RAR_OP_ROTATE_LEFT_VIA_CARRY: begin
								retire <= 1'b1;
							end
							default: begin
							end
						endcase
					end
				end
				rar_pkg::RAR_ST_FLUSH: begin
					state_q <= rar_pkg::RAR_ST_IDLE;
					retire  <= 1'b1;
				end
			endcase
		end
	end

	// Program counter and stack pulses
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pc_load   <= 1'b0;
			stack_pop <= 1'b0;
			pc_value  <= `RAR_RST_PC;
		end else begin
			pc_load   <= 1'b0;
			stack_pop <= 1'b0;
			if (take && (op == rar_pkg::RAR_OP_RETURN_WITH_LITERAL || op == rar_pkg::RAR_OP_RETURN)) begin
				pc_load   <= 1'b1;
				stack_pop <= 1'b1;
				pc_value  <= stack_top_entry;
			end
		end
	end

	// Accumulator and file register writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			w_we       <= 1'b0;
			w_wdata    <= `RAR_RST_DATA;
			file_we    <= 1'b0;
			file_waddr <= `RAR_RST_FILE;
			file_wdata <= `RAR_RST_DATA;
		end else begin
			w_we    <= 1'b0;
			file_we <= 1'b0;
			if (take) begin
				if (op == rar_pkg::RAR_OP_RETURN_WITH_LITERAL) begin
					w_we    <= 1'b1;
					w_wdata <= instr_literal;
				end else if (op == rar_pkg::RAR_OP_ROTATE_LEFT_VIA_CARRY) begin
					if (instr_dest) begin
						file_we    <= 1'b1;
						file_waddr <= instr_file_idx;
						file_wdata <= rot[`RAR_DATA_W-1:0];
					end else begin
						w_we    <= 1'b1;
						w_wdata <= rot[`RAR_DATA_W-1:0];
					end
				end
			end
		end
	end

	// Carry only; no other flag is driven, so returns leave all flags alone
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			carry_we    <= 1'b0;
			carry_wdata <= 1'b0;
		end else begin
			carry_we <= 1'b0;
			if (take && op == rar_pkg::RAR_OP_ROTATE_LEFT_VIA_CARRY) begin
				carry_we    <= 1'b1;
				carry_wdata <= rot[`RAR_DATA_W];
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	logic take_lit;
	logic take_ret;
	logic take_rot;
	assign take_lit = take && op == rar_pkg::RAR_OP_RETURN_WITH_LITERAL;
	assign take_ret = take && op == rar_pkg::RAR_OP_RETURN;
	assign take_rot = take && op == rar_pkg::RAR_OP_ROTATE_LEFT_VIA_CARRY;

	property p_lit_w;
		take_lit |=> w_we && !file_we && w_wdata == $past(instr_literal);
	endproperty
	a_lit_w: assert property (p_lit_w) else $error("literal not written to accumulator");

	property p_lit_pc;
		take_lit |=> pc_load && stack_pop && pc_value == $past(stack_top_entry);
	endproperty
	a_lit_pc: assert property (p_lit_pc) else $error("literal return did not redirect");

	property p_lit_cyc;
		take_lit |=> !instr_ready && !retire ##1 instr_ready && retire && !pc_load;
	endproperty
	a_lit_cyc: assert property (p_lit_cyc) else $error("literal return not two cycles");

	property p_ret_pc;
		take_ret |=> pc_load && stack_pop && !w_we && pc_value == $past(stack_top_entry);
	endproperty
	a_ret_pc: assert property (p_ret_pc) else $error("return did not redirect");

	property p_ret_cyc;
		take_ret |=> !instr_ready ##1 instr_ready && retire;
	endproperty
	a_ret_cyc: assert property (p_ret_cyc) else $error("return not two cycles");

	property p_rot_val;
		take_rot |=> (w_we ? w_wdata : file_wdata) == {$past(file_rdata[`RAR_DATA_W-2:0]), $past(carry_in)};
	endproperty
	a_rot_val: assert property (p_rot_val) else $error("rotate result wrong");

	property p_rot_dest;
		take_rot |=> (file_we == $past(instr_dest)) && (w_we != $past(instr_dest));
	endproperty
	a_rot_dest: assert property (p_rot_dest) else $error("rotate destination wrong");

	property p_rot_addr;
		take_rot && instr_dest |=> file_waddr == $past(instr_file_idx);
	endproperty
	a_rot_addr: assert property (p_rot_addr) else $error("rotate file address wrong");

	property p_rot_carry;
		take_rot |=> carry_we && carry_wdata == $past(file_rdata[`RAR_DATA_W-1]) && !pc_load;
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");

	property p_flags;
		(take_lit || take_ret) |=> !carry_we ##1 !carry_we;
	endproperty
	a_flags: assert property (p_flags) else $error("return touched carry");

	property p_rot_one;
		take_rot |=> instr_ready && retire;
	endproperty
	a_rot_one: assert property (p_rot_one) else $error("rotate not single cycle");

	c_lit: cover property (take_lit ##2 take_rot);
	c_ret: cover property (take_ret ##2 take_ret);
	c_rot: cover property (take_rot && instr_dest ##1 take_rot && !instr_dest);

endmodule : rar_exec
`default_nettype wire

// >>> return_and_rotate_exec_bench.sv
// Self-checking bench for the return and rotate executor.
// Assumes rar_cfg.svh on the include path; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`include "rar_cfg.svh"

module return_and_rotate_exec_bench;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        instr_valid = 1'b0;
	logic [1:0]  instr_op = 2'h0;
	logic [7:0]  instr_literal = 8'h00;
	logic [6:0]  instr_file_idx = 7'h00;
	logic        instr_dest = 1'b0;
	logic [7:0]  file_rdata = 8'h00;
	logic        carry_in = 1'b0;
	logic [8:0]  stack_top_entry = 9'h000;
	logic        instr_ready, retire, w_we, file_we, carry_we, carry_wdata, pc_load, stack_pop;
	logic [7:0]  w_wdata, file_wdata;
	logic [6:0]  file_waddr;
	logic [8:0]  pc_value;
	logic [37:0] act;
	logic [37:0] exp_q[$];
	int          num_errors = 0;
	int          check_count = 0;
	int          seed = 14166;

	always #20 clk_sys = ~clk_sys;

	rar_exec uut (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_literal(instr_literal), .instr_file_idx(instr_file_idx), .instr_dest(instr_dest),
		.instr_ready(instr_ready), .retire(retire), .file_rdata(file_rdata), .carry_in(carry_in),
		.stack_top_entry(stack_top_entry), .w_we(w_we), .w_wdata(w_wdata), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .carry_we(carry_we), .carry_wdata(carry_wdata),
		.pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop));

	// Data fields only count while their strobe is high
	function automatic logic [37:0] pack(input logic ww, input logic [7:0] wd, input logic fw,
		input logic [6:0] fa, input logic [7:0] fd, input logic cw, input logic cd, input logic pl,
		input logic [8:0] pv, input logic sp);
		pack = {ww, ww ? wd : 8'h00, fw, fw ? {fa, fd} : 15'h0000, cw, cw ? cd : 1'b0, pl, pl ? pv : 9'h000, sp};
	endfunction : pack

	assign act = pack(w_we, w_wdata, file_we, file_waddr, file_wdata, carry_we, carry_wdata, pc_load, pc_value,
		stack_pop);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [37:0] exp_v, input logic [37:0] got_v);
		check_count++;
		if (got_v !== exp_v) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp_v, got_v);
		end
	endtask : chk

	// Watcher: every write cycle consumes the oldest note
	always @(negedge clk_sys) begin
		// An unknown strobe is checked too, so it cannot slip through as idle
		if (resetn === 1'b1 && (w_we | file_we | carry_we | pc_load | stack_pop) !== 1'b0) begin
			if (exp_q.size() == 0)
				chk("unexpected write", 38'h0, act);
			else
				chk("write pulses", exp_q.pop_front(), act);
		end
	end

	task automatic issue(input logic [1:0] op, input logic [31:0] rv);
		int         n;
		logic [7:0] r;
		instr_valid = 1'b1;
		instr_op = op;
		{instr_literal, file_rdata, instr_file_idx, instr_dest} = rv[23:0];
		carry_in = rv[24];
		stack_top_entry = {rv[31], rv[15:8]};
		r = {file_rdata[6:0], carry_in};
		n = 0;
		while (instr_ready !== 1'b1 && n < 10) begin
			@(negedge clk_sys);
			n++;
		end
		if (instr_ready !== 1'b1) begin
			num_errors++;
			tally_and_finish();
		end
		if (op == 2'h0)
			exp_q.push_back(pack(1'b1, instr_literal, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0, 1'b1, stack_top_entry, 1'b1));
		else if (op == 2'h1)
			exp_q.push_back(pack(1'b0, 8'h00, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0, 1'b1, stack_top_entry, 1'b1));
		else if (op == 2'h2)
			exp_q.push_back(pack(!instr_dest, r, instr_dest, instr_file_idx, r, 1'b1, file_rdata[7], 1'b0,
				9'h000, 1'b0));
		@(negedge clk_sys);
		if (op == 2'h2)
			chk("ready retire after rotate", 38'h3, {36'h0, instr_ready, retire});
		else if (op == 2'h3)
			chk("retire after ignored op", 38'h0, {37'h0, retire});
		else begin
			chk("ready retire flush cycle", 38'h0, {36'h0, instr_ready, retire});
			@(negedge clk_sys);
			chk("ready retire after return", 38'h3, {36'h0, instr_ready, retire});
		end
	endtask : issue

	initial begin
		repeat (2) @(negedge clk_sys);
		chk("outputs in reset", 38'h0, {act[37:1], instr_ready | retire | stack_pop});
		resetn = 1'b1;
		@(negedge clk_sys);
		issue(2'h0, 32'h00000000);
		issue(2'h0, 32'h81ff0000);
		issue(2'h0, $random(seed));
		$display("test literal return done");
		issue(2'h1, $random(seed));
		issue(2'h1, $random(seed));
		$display("test plain return done");
		issue(2'h2, 32'h0000e600);
		issue(2'h2, 32'h0100e6ff);
		for (int i = 0; i < 12; i++)
			issue(2'h2, $random(seed));
		$display("test rotate done");
		issue(2'h3, $random(seed));
		issue(2'h2, $random(seed));
		issue(2'h0, $random(seed));
		issue(2'h2, $random(seed));
		$display("test mixed sequence done");
		instr_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk("notes left over", 38'h0, 38'(exp_q.size()));
		tally_and_finish();
	end
endmodule : return_and_rotate_exec_bench

`default_nettype wire
